// File: core/bfl_core.sv
// Breaker failure decision logic: start timers, supervision and trip outputs
`timescale 1ns/1ps
`default_nettype none
`include "bfl_consts.svh"

// Overview of operation
// - Start edge launches backup and retrip timers per phase
// - Supervise current, contact or both while running
// - Current mode uses only overcurrent flags
// - Contact mode uses common or per-phase breaker input
// - Combined mode idles only when all faultless
// - Operation Off gives no trip outputs
// - Backup trip when delay ends and fault persists
// - Trip outputs last at least pulse duration
// - Single-pole retrip per phase when enabled
// - Blocking input inhibits the whole function
// - Per-phase overcurrent flags for three phases
// - Residual flag qualified by residual start input
// - Backup delay 100 to 60000 ms, default 1000
// - Retrip delay 0 to 1000 ms, default 100
// - Pulse duration 0 to 60000 ms

module bfl_core #(
  parameter int unsigned TICK_CYCLES = `BFL_TICK_CYCLES
) (
  input  wire logic              CORE_CLK,        // 200 MHz core clock
  input  wire logic              RESETN,          // Asynchronous reset, active low
  input  wire logic              SYNC_CLR,        // Synchronous clear of timers and trips
  input  wire logic              BLOCK_IN,        // Dynamic blocking, active high
  input  wire bfl_pkg::bfl_start_t START_IN,      // Start inputs
  input  wire bfl_pkg::bfl_cond_t  COND_IN,       // Current flags and breaker status
  input  wire logic              CFG_DEFAULTS,    // Use default settings instead of CFG_IN
  input  wire bfl_pkg::bfl_cfg_t CFG_IN,          // Settings
  output logic                   BACKUP_TRIP_OUT, // Backup trip command
  output logic [2:0]             RETRIP_OUT,      // Phase 3..1 retrip commands
  output logic                   ACTIVE_OUT,      // Some backup timer running
  output logic                   ENABLED_OUT      // Function on and not blocked
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Starts, flags and block arrive from foreign logic; two flops each.
  // Every synchronised level resets low, so no false start edge and no
  // phantom block appear right after reset.
  // The cost is two cycles of latency on every start and every flag.
  localparam int unsigned NSYNC = 14;

  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign sync_raw = {BLOCK_IN, START_IN, COND_IN};

  generate
    for (genvar k = 0; k < NSYNC; k++) begin : g_sync
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          sync1_r[k] <= 1'h0;
          sync2_r[k] <= 1'h0;
        end else begin
          sync1_r[k] <= sync_raw[k];
          sync2_r[k] <= sync1_r[k];
        end
      end
    end
  endgenerate

  logic               blk;
  bfl_pkg::bfl_start_t st;
  bfl_pkg::bfl_cond_t  cond;

  assign blk  = sync2_r[13];
  assign st   = bfl_pkg::bfl_start_t'(sync2_r[12:8]);
  assign cond = bfl_pkg::bfl_cond_t'(sync2_r[7:0]);

  // ****************************************************************
  // Settings: defaults, range limits
  // ****************************************************************
  bfl_pkg::bfl_cfg_t cfg_sel;
  bfl_pkg::bfl_cfg_t cfg_r;
  bfl_pkg::bfl_cfg_t cfg_nxt;

  always_comb begin
    cfg_sel = CFG_IN;
    if (CFG_DEFAULTS) begin
      cfg_sel.op              = bfl_pkg::BFL_OP_OFF;
      cfg_sel.retrip_en       = `BFL_RETRIP_EN_DEF;
      cfg_sel.backup_delay_ms = `BFL_BACKUP_DEF_MS;
      cfg_sel.retrip_delay_ms = `BFL_RETRIP_DEF_MS;
      cfg_sel.pulse_ms        = `BFL_PULSE_DEF_MS;
    end
  end

  // Out-of-range settings saturate rather than wrap, so a bad value
  // never turns a long delay into a short one.
  always_comb begin
    cfg_nxt = cfg_sel;
    if (cfg_sel.backup_delay_ms < `BFL_BACKUP_MIN_MS) begin
      cfg_nxt.backup_delay_ms = `BFL_BACKUP_MIN_MS;
    end else if (cfg_sel.backup_delay_ms > `BFL_BACKUP_MAX_MS) begin
      cfg_nxt.backup_delay_ms = `BFL_BACKUP_MAX_MS;
    end
    if (cfg_sel.retrip_delay_ms > `BFL_RETRIP_MAX_MS) begin
      cfg_nxt.retrip_delay_ms = `BFL_RETRIP_MAX_MS;
    end
    if (cfg_sel.pulse_ms > `BFL_PULSE_MAX_MS) begin
      cfg_nxt.pulse_ms = `BFL_PULSE_MAX_MS;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r.op                  <= bfl_pkg::BFL_OP_OFF;
      cfg_r.single_pole_variant <= 1'h0;
      cfg_r.retrip_en           <= `BFL_RETRIP_EN_DEF;
      cfg_r.backup_delay_ms     <= `BFL_BACKUP_DEF_MS;
      cfg_r.retrip_delay_ms     <= `BFL_RETRIP_DEF_MS;
      cfg_r.pulse_ms            <= `BFL_PULSE_DEF_MS;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // Settings are registered once; they are meant to change only while
  // every timer is idle, so no synchroniser is spent on them.
  logic op_off;
  logic use_cur;
  logic use_cnt;
  logic sp;
  logic clr;

  always_comb begin
    op_off  = 1'h0;
    use_cur = 1'h0;
    use_cnt = 1'h0;
    unique case (cfg_r.op)
      bfl_pkg::BFL_OP_OFF:             op_off  = 1'h1;
      bfl_pkg::BFL_OP_CURRENT:         use_cur = 1'h1;
      bfl_pkg::BFL_OP_CONTACT:         use_cnt = 1'h1;
      bfl_pkg::BFL_OP_CURRENT_CONTACT: begin
        use_cur = 1'h1;
        use_cnt = 1'h1;
      end
    endcase
  end

  assign sp  = cfg_r.single_pole_variant;
  // Block, Off and the synchronous clear all abort every timer and
  // drop any trip at once; blocking wins over a running pulse.
  assign clr = SYNC_CLR || blk || op_off;

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  // The prescaler runs free and restarts only on the synchronous clear,
  // so the first millisecond of any delay may be partial: a delay of
  // D ms really lasts between D-1 and D ms.
  logic tick;

  bfl_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .clr   (SYNC_CLR),
    .tick  (tick)
  );

  // ****************************************************************
  // Fault conditions
  // ****************************************************************
  // A fault persists while any supervised quantity is still faulty, so
  // the combined mode resets only when current is low and breaker open.
  logic       res_fault;
  logic [2:0] ph_fault;
  logic       com_fault;
  logic [2:0] ph_start;
  logic       com_start;

  assign res_fault = cond.residual_overcurrent_flag && st.residual_start_in;

  generate
    for (genvar p = 0; p < 3; p++) begin : g_fault
      assign ph_fault[p] =
        (use_cur && (cond.phase_overcurrent_flag[p] || res_fault)) ||
        (use_cnt && cond.phase_breaker_closed_in[p]);
    end
  endgenerate

  assign com_fault =
    (use_cur && ((|cond.phase_overcurrent_flag) || res_fault)) ||
    (use_cnt && cond.breaker_closed_in);

  // In the single-pole variant the general start starts all phases.
  assign ph_start = sp ? ({st.phase3_start_in, st.phase2_start_in,
                           st.phase1_start_in} | {3{st.general_start_in}})
                       : 3'h0;
  assign com_start = !sp && st.general_start_in;

  // ****************************************************************
  // Timers
  // ****************************************************************
  // Per-phase timers serve the single-pole variant, the common timer the
  // common-phase variant; the unused set never sees a start edge.
  logic [2:0] bu_run;
  logic [2:0] bu_trip;
  logic [2:0] rt_trip;
  logic       com_run;
  logic       com_trip;

  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      bfl_chan u_backup (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .clr     (clr),
        .tick    (tick),
        .start   (ph_start[p]),
        .delay   (cfg_r.backup_delay_ms),
        .pulse   (cfg_r.pulse_ms),
        .fault   (ph_fault[p]),
        .running (bu_run[p]),
        .trip_r  (bu_trip[p])
      );

      // Retrip fires only where this phase's backup timer still runs.
      bfl_chan u_retrip (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .clr     (clr || !cfg_r.retrip_en),
        .tick    (tick),
        .start   (ph_start[p]),
        .delay   (cfg_r.retrip_delay_ms),
        .pulse   (cfg_r.pulse_ms),
        .fault   (bu_run[p] && cfg_r.retrip_en),
        .running (),
        .trip_r  (rt_trip[p])
      );
    end
  endgenerate

  bfl_chan u_common (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .clr     (clr),
    .tick    (tick),
    .start   (com_start),
    .delay   (cfg_r.backup_delay_ms),
    .pulse   (cfg_r.pulse_ms),
    .fault   (com_fault),
    .running (com_run),
    .trip_r  (com_trip)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BACKUP_TRIP_OUT <= 1'h0;
    end else if (clr) begin
      BACKUP_TRIP_OUT <= 1'h0;
    end else begin
      BACKUP_TRIP_OUT <= com_trip || (|bu_trip);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RETRIP_OUT <= 3'h0;
    end else if (clr || !sp) begin
      RETRIP_OUT <= 3'h0;
    end else begin
      RETRIP_OUT <= rt_trip;
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  // Active shows only the backup timers; a pulse in hold does not count.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACTIVE_OUT <= 1'h0;
    end else begin
      ACTIVE_OUT <= com_run || (|bu_run);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ENABLED_OUT <= 1'h0;
    end else begin
      ENABLED_OUT <= !op_off && !blk;
    end
  end

endmodule

`default_nettype wire

// File: core/bfl_consts.svh
// Timing, setting range and default constants of the breaker failure logic
`ifndef BFL_CONSTS_SVH
`define BFL_CONSTS_SVH

// ****************************************************************
// Clock and millisecond tick
// ****************************************************************
`define BFL_CLK_MHZ            200
`define BFL_TICK_MS            1
`define BFL_TICK_CYCLES        (`BFL_TICK_MS * `BFL_CLK_MHZ * 1000)

// ****************************************************************
// Setting ranges and defaults, delays and pulse in milliseconds
// ****************************************************************
`define BFL_BACKUP_MIN_MS      16'h0064
`define BFL_BACKUP_MAX_MS      16'hea60
`define BFL_BACKUP_DEF_MS      16'h03e8
`define BFL_RETRIP_MAX_MS      16'h03e8
`define BFL_RETRIP_DEF_MS      16'h0064
`define BFL_PULSE_MAX_MS       16'hea60
`define BFL_PULSE_DEF_MS       16'h0064
`define BFL_RETRIP_EN_DEF      1'h0

// ****************************************************************
// Synchroniser reset value
// ****************************************************************
`define BFL_SYNC_RST           14'h0000

`endif

// File: core/bfl_pkg.sv
// Types shared by the breaker failure logic
package bfl_pkg;

  // Operation setting
  typedef enum logic [1:0] {
    BFL_OP_OFF,
    BFL_OP_CURRENT,
    BFL_OP_CONTACT,
    BFL_OP_CURRENT_CONTACT
  } bfl_op_t;

  // Start inputs, from other protection functions
  typedef struct packed {
    logic       general_start_in;
    logic       phase3_start_in;
    logic       phase2_start_in;
    logic       phase1_start_in;
    logic       residual_start_in;
  } bfl_start_t;

  // Current threshold flags and breaker status
  typedef struct packed {
    logic [2:0] phase_overcurrent_flag;   // [0] phase 1 .. [2] phase 3
    logic       residual_overcurrent_flag;
    logic       breaker_closed_in;
    logic [2:0] phase_breaker_closed_in;  // [0] phase 1 .. [2] phase 3
  } bfl_cond_t;

  // Settings
  typedef struct packed {
    bfl_op_t     op;
    logic        single_pole_variant;
    logic        retrip_en;
    logic [15:0] backup_delay_ms;
    logic [15:0] retrip_delay_ms;
    logic [15:0] pulse_ms;
  } bfl_cfg_t;

endpackage

// File: core/bfl_tick.sv
// Millisecond tick prescaler for the breaker failure logic
`timescale 1ns/1ps
`default_nettype none

module bfl_tick #(
  parameter int unsigned CYCLES = 200000
) (
  input  wire logic clk,     // Core clock
  input  wire logic rst_n,   // Asynchronous reset, active low
  input  wire logic clr,     // Restart the millisecond period
  output logic      tick     // One-cycle pulse per millisecond
);

  localparam logic [17:0] LAST = 18'(CYCLES - 1);

  logic [17:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 18'h00000;
    end else if (clr || cnt_r == LAST) begin
      cnt_r <= 18'h00000;
    end else begin
      cnt_r <= cnt_r + 18'h00001;
    end
  end

  assign tick = (cnt_r == LAST) && !clr;

endmodule

`default_nettype wire

// File: core/bfl_chan.sv
// One delay timer with its minimum-length trip pulse
`timescale 1ns/1ps
`default_nettype none

module bfl_chan (
  input  wire logic        clk,      // Core clock
  input  wire logic        rst_n,    // Asynchronous reset, active low
  input  wire logic        clr,      // Abort timer and drop trip
  input  wire logic        tick,     // Millisecond tick
  input  wire logic        start,    // Start level, edge launches timer
  input  wire logic [15:0] delay,    // Delay in ms
  input  wire logic [15:0] pulse,    // Least trip length in ms
  input  wire logic        fault,    // Trip wanted at expiry
  output logic             running,  // Timer counting
  output logic             trip_r    // Trip pulse
);

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_HOLD} bfl_chan_st_t;

  bfl_chan_st_t st_r;
  logic [15:0]  cnt_r;
  logic         start_d_r;

  wire rise = start && !start_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_d_r <= 1'h0;
    end else begin
      start_d_r <= start;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= S_IDLE;
      cnt_r  <= 16'h0000;
      trip_r <= 1'h0;
    end else if (clr) begin
      st_r   <= S_IDLE;
      cnt_r  <= 16'h0000;
      trip_r <= 1'h0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (rise) begin
            st_r  <= S_RUN;
            cnt_r <= 16'h0000;
          end
        end
        S_RUN: begin
          if (!start) begin
            st_r <= S_IDLE;
          end else if (cnt_r >= delay) begin
            cnt_r <= 16'h0000;
            if (fault) begin
              st_r   <= S_HOLD;
              trip_r <= 1'h1;
            end else begin
              st_r <= S_IDLE;
            end
          end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        S_HOLD: begin
          // Held for the pulse time, then as long as the fault stays started
          if (cnt_r >= pulse && !(start && fault)) begin
            st_r   <= S_IDLE;
            trip_r <= 1'h0;
          end else if (tick && cnt_r != 16'hffff) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
      endcase
    end
  end

  assign running = (st_r == S_RUN);

endmodule

`default_nettype wire

// File: bench/bfl_core_props.sv
// Port-level checker for the breaker failure logic
`timescale 1ns/1ps
`default_nettype none

module bfl_core_props #(
  parameter int unsigned TICK_CYCLES = 200000
) (
  input wire logic                CORE_CLK,        // Clock
  input wire logic                RESETN,          // Reset, active low
  input wire logic                SYNC_CLR,        // Sync clear
  input wire logic                BLOCK_IN,        // Blocking
  input wire bfl_pkg::bfl_start_t START_IN,        // Starts
  input wire bfl_pkg::bfl_cond_t  COND_IN,         // Flags
  input wire logic                CFG_DEFAULTS,    // Defaults
  input wire bfl_pkg::bfl_cfg_t   CFG_IN,          // Settings
  input wire logic                BACKUP_TRIP_OUT, // Backup trip
  input wire logic [2:0]          RETRIP_OUT,      // Retrips
  input wire logic                ACTIVE_OUT,      // Running
  input wire logic                ENABLED_OUT      // Enabled
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  logic        off_c;
  logic        flt_c;
  logic [5:0]  flt_h;
  logic [7:0]  calm_r;
  int unsigned hi_r;

  assign off_c = CFG_DEFAULTS || CFG_IN.op == bfl_pkg::BFL_OP_OFF;
  assign flt_c = (CFG_IN.op != bfl_pkg::BFL_OP_CONTACT && (|COND_IN[7:4]))
              || (CFG_IN.op != bfl_pkg::BFL_OP_CURRENT && (|COND_IN[3:0]));

  // Short history, since the pins reach the timers through synchronisers
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flt_h <= 6'h00;
    end else begin
      flt_h <= {flt_h[4:0], flt_c};
    end
  end

  // A kill may cut a pulse short, so pulse checks wait for a calm spell
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      calm_r <= 8'h00;
      hi_r   <= 0;
    end else begin
      calm_r <= (BLOCK_IN || SYNC_CLR || off_c) ? 8'h00 : calm_r + {7'h00, calm_r != 8'hff};
      hi_r   <= BACKUP_TRIP_OUT ? hi_r + 1 : 0;
    end
  end

  sequence s_blocked;
    BLOCK_IN [*5];
  endsequence

  sequence s_no_start;
    (START_IN == 5'h00) [*6];
  endsequence

  a_block_quiet: assert property (s_blocked |-> !BACKUP_TRIP_OUT && !ACTIVE_OUT
    && RETRIP_OUT == 3'h0 && !ENABLED_OUT) else $error("block left output");
  a_off_quiet: assert property (off_c [*4] |-> !BACKUP_TRIP_OUT && !ACTIVE_OUT
    && RETRIP_OUT == 3'h0 && !ENABLED_OUT) else $error("off left output");
  a_enable_on: assert property ((!BLOCK_IN && !off_c) [*5] |-> ENABLED_OUT)
    else $error("enable missing");
  a_clear_quiet: assert property (SYNC_CLR [*2] |=> !BACKUP_TRIP_OUT && !ACTIVE_OUT
    && RETRIP_OUT == 3'h0) else $error("clear left output");
  a_abort_idle: assert property (s_no_start |-> !ACTIVE_OUT)
    else $error("timer runs without start");
  a_trip_after_run: assert property ($rose(BACKUP_TRIP_OUT) |-> $past(ACTIVE_OUT)
    || $past(ACTIVE_OUT, 2)) else $error("trip without timer");
  a_trip_has_fault: assert property ($rose(BACKUP_TRIP_OUT) |-> |flt_h)
    else $error("trip without fault");
  a_pulse_min: assert property ($fell(BACKUP_TRIP_OUT) && calm_r > 8'h08
    |-> hi_r + TICK_CYCLES >= CFG_IN.pulse_ms * TICK_CYCLES) else $error("pulse short");
  a_retrip_gate: assert property (|RETRIP_OUT |-> CFG_IN.single_pole_variant
    && CFG_IN.retrip_en && !CFG_DEFAULTS) else $error("retrip not enabled");
endmodule

bind bfl_core bfl_core_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SYNC_CLR(SYNC_CLR), .BLOCK_IN(BLOCK_IN),
  .START_IN(START_IN), .COND_IN(COND_IN), .CFG_DEFAULTS(CFG_DEFAULTS), .CFG_IN(CFG_IN),
  .BACKUP_TRIP_OUT(BACKUP_TRIP_OUT), .RETRIP_OUT(RETRIP_OUT), .ACTIVE_OUT(ACTIVE_OUT),
  .ENABLED_OUT(ENABLED_OUT));

`default_nettype wire

// File: bench/bfl_partner.sv
// Model of the starting protection and the circuit breaker
`timescale 1ns/1ps
`default_nettype none

module bfl_partner (
  input  wire logic           clk,    // Clock
  input  wire logic           stuck,  // Breaker fails to open
  input  wire logic [4:0]     st_req, // Starts wanted
  input  wire logic [7:0]     cd_req, // Flags wanted
  input  wire logic           trip,   // Any trip
  output var bfl_pkg::bfl_start_t start, // Start levels
  output var bfl_pkg::bfl_cond_t  cond   // Flags and contacts
);
  logic [1:0] open_r;

  // A healthy breaker opens two cycles into a trip
  always_ff @(posedge clk) begin
    if (st_req == 5'h00) begin
      open_r <= 2'h0;
    end else if (trip && !stuck && open_r != 2'h2) begin
      open_r <= open_r + 2'h1;
    end
  end

  // Protection drops its start once the fault is gone
  assign start = (open_r == 2'h2) ? 5'h00 : st_req;
  assign cond  = (open_r == 2'h2) ? 8'h00 : cd_req;
endmodule

`default_nettype wire

// File: bench/bfl_core_bench.sv
// Self-checking bench for the breaker failure logic
`timescale 1ns/1ps
`default_nettype none

module bfl_core_bench;
  localparam int TK = 4;
  logic                clk;
  logic                rst_n;
  logic                sclr;
  logic                blk;
  logic                dflt;
  logic                stuck;
  logic [4:0]          st_req;
  logic [7:0]          cd_req;
  bfl_pkg::bfl_start_t start;
  bfl_pkg::bfl_cond_t  cond;
  bfl_pkg::bfl_cfg_t   cfg;
  logic                bk;
  logic [2:0]          rt;
  logic                act;
  logic                en;
  logic [7:0]          cv [4];
  logic [15:0]         mask;
  int                  err_count;
  int                  tests_run;
  int                  n;

  bfl_core #(.TICK_CYCLES(TK)) dut (
    .CORE_CLK(clk), .RESETN(rst_n), .SYNC_CLR(sclr), .BLOCK_IN(blk), .START_IN(start),
    .COND_IN(cond), .CFG_DEFAULTS(dflt), .CFG_IN(cfg), .BACKUP_TRIP_OUT(bk),
    .RETRIP_OUT(rt), .ACTIVE_OUT(act), .ENABLED_OUT(en));

  bfl_partner u_far (.clk(clk), .stuck(stuck), .st_req(st_req), .cd_req(cd_req),
    .trip(bk || (|rt)), .start(start), .cond(cond));

  always #2.5 clk = ~clk;

  // ********************
  // Access tasks
  // ********************
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic setc(input bfl_pkg::bfl_op_t o, input logic sp, input logic re,
                      input logic [15:0] bd, input logic [15:0] pl);
    cfg = '{o, sp, re, bd, 16'h000a, pl};
    cyc(3);
  endtask

  // Apply a start and count cycles until a trip, bounded by lim
  task automatic fire(input logic [4:0] s, input logic [7:0] c, input int lim);
    st_req = s;
    cd_req = c;
    n = 0;
    while (bk !== 1'b1 && rt === 3'h0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic idle();
    st_req = 5'h00;
    cd_req = 8'h00;
    cyc(12);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    clk = 0; rst_n = 0; sclr = 0; blk = 0; dflt = 0; stuck = 1;
    st_req = 5'h00; cd_req = 8'h00; err_count = 0; tests_run = 0;
    cfg = '{bfl_pkg::BFL_OP_OFF, 1'b0, 1'b0, 16'h0064, 16'h000a, 16'h0000};
    cv = '{8'h20, 8'h08, 8'h10, 8'h00};
    mask = 16'h7250;
    cyc(8);
    rst_n = 1;
    cyc(1);
    chk("reset outs", 16'h0, {bk, rt, act, en});
    fire(5'h10, 8'hff, 420);
    chk("off trip", 16'h0, {bk, en});
    idle();
    // Each operation other than Off against each single fault kind
    for (int m = 1; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        setc(bfl_pkg::bfl_op_t'(m), 1'b0, 1'b0, 16'h0064, 16'h0000);
        fire(5'h11, cv[k], 420);
        chk("mode trip", 16'(mask[m * 4 + k]), 16'(n < 420));
        if (mask[m * 4 + k]) begin
          chk("delay", 16'h1, 16'(n > 396));
        end
        idle();
      end
    end
    fire(5'h10, 8'h10, 420);
    chk("residual gate", 16'h0, 16'(bk));
    idle();
    setc(bfl_pkg::BFL_OP_CURRENT, 1'b0, 1'b0, 16'h0032, 16'h0000);
    fire(5'h10, 8'h20, 420);
    chk("clamped delay", 16'h1, 16'(n > 396 && n < 420));
    sclr = 1;
    cyc(2);
    sclr = 0;
    chk("clear", 16'h0, {bk, rt, act});
    fire(5'h10, 8'h20, 420);
    chk("no edge", 16'h0, 16'(bk));
    idle();
    st_req = 5'h10;
    cd_req = 8'h20;
    cyc(200);
    st_req = 5'h00;
    cyc(4);
    fire(5'h10, 8'h20, 420);
    chk("abort restart", 16'h1, 16'(n > 396 && n < 420));
    idle();
    st_req = 5'h10;
    cyc(200);
    chk("active", 16'h1, 16'(act));
    blk = 1;
    cyc(6);
    chk("block", 16'h0, {act, en});
    fire(5'h10, 8'h20, 300);
    chk("block trip", 16'h0, 16'(bk));
    blk = 0;
    idle();
    setc(bfl_pkg::BFL_OP_CURRENT, 1'b0, 1'b0, 16'h0064, 16'h0014);
    stuck = 0;
    fire(5'h10, 8'h20, 420);
    n = 0;
    while (bk === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("pulse", 16'h1, 16'(n >= 19 * TK && n < 100));
    stuck = 1;
    idle();
    setc(bfl_pkg::BFL_OP_CURRENT, 1'b1, 1'b1, 16'h0064, 16'h0000);
    fire(5'h04, 8'h40, 60);
    chk("retrip", 16'h2, 16'(rt));
    idle();
    setc(bfl_pkg::BFL_OP_CURRENT, 1'b1, 1'b0, 16'h0064, 16'h0000);
    fire(5'h04, 8'h40, 60);
    chk("retrip off", 16'h0, 16'(rt));
    idle();
    setc(bfl_pkg::BFL_OP_CONTACT, 1'b1, 1'b0, 16'h0064, 16'h0000);
    fire(5'h02, 8'h02, 420);
    chk("pole contact", 16'h0, 16'(bk));
    idle();
    fire(5'h02, 8'h01, 420);
    chk("pole trip", 16'h1, 16'(bk));
    idle();
    dflt = 1;
    cyc(4);
    chk("defaults off", 16'h0, 16'(en));
    complete_run();
  end
endmodule

`default_nettype wire
